// ==== shared/mia_pkg.sv ====
// mia_pkg: constants and types for the indirect extended-register access block
// assumes a 16-bit direct register space with 5-bit register numbers
package mia_pkg;

  // direct register numbers of the two access registers
  localparam logic [4:0]  MIA_CTRL_ADDR   = 5'h0_D;
  localparam logic [4:0]  MIA_PORT_ADDR   = 5'h0_E;

  // control register field positions
  localparam int          MIA_FUNC_HI     = 15;
  localparam int          MIA_FUNC_LO     = 14;
  localparam int          MIA_SEL_HI      = 4;
  localparam int          MIA_SEL_LO      = 0;

  // only supported manageable-device selector
  localparam logic [4:0]  MIA_SEL_GENERAL = 5'h1_F;

  // access function codes
  localparam logic [1:0]  MIA_FN_ADDR     = 2'h0;
  localparam logic [1:0]  MIA_FN_DATA     = 2'h1;
  localparam logic [1:0]  MIA_FN_INC_RW   = 2'h2;
  localparam logic [1:0]  MIA_FN_INC_WR   = 2'h3;

  // reset values
  localparam logic [1:0]  MIA_FUNC_RST    = 2'h0;
  localparam logic [4:0]  MIA_SEL_RST     = 5'h0_0;
  localparam logic [15:0] MIA_XADDR_RST   = 16'h0000;
  localparam logic [15:0] MIA_DATA_RST    = 16'h0000;

  // read-back of an ignored indirect access
  localparam logic [15:0] MIA_IGNORED_RD  = 16'h0000;

  typedef enum logic [0:0] {
    MIA_IDLE,
    MIA_RD_WAIT
  } mia_state_t;

endpackage : mia_pkg

// ==== rtl/mia_ptr_step.sv ====
// mia_ptr_step: next value of the extended-address register after a data access
// assumes the caller only asserts done_in for accepted data-function accesses
`timescale 1ns/1ps
`default_nettype none

module mia_ptr_step
  import mia_pkg::*;
(
  input  wire logic [1:0]  func_in,   // current access function
  input  wire logic [15:0] addr_in,   // current extended address
  input  wire logic        wr_in,     // 1 write, 0 read
  input  wire logic        done_in,   // access completes this cycle
  output logic      [15:0] addr_out   // address after the access
);

  logic bump;

  always_comb begin
    bump = 1'b0;
    if (done_in) begin
      case (func_in)
        MIA_FN_INC_RW: bump = 1'b1;
        MIA_FN_INC_WR: bump = wr_in;
        default:       bump = 1'b0;
      endcase
    end
    addr_out = bump ? 16'(addr_in + 16'h0001) : addr_in;
  end

endmodule // mia_ptr_step

`default_nettype wire

// ==== rtl/mia_indirect_access.sv ====
// mia_indirect_access: control and address/data port registers giving indirect
// access to the extended register space
// assumes the direct register decoder gives one-cycle read/write strobes and
// waits while busy_out is high; the extended space answers reads combinationally
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - The extended set is reached through the control register at 0xD and the port at 0xE.
// - Registers 0 to 31 are reachable indirectly too, but indirect hits on 0xD and 0xE are ignored.
// - Control bits 4:0 hold the device selector steering every port access.
// - Only selector 11111 is served; port accesses under any other selector are ignored.
// - Control bits 15:14 pick address, data, data with increment on all, data with increment on writes.
// - With function 00 a port write loads the extended-address register, again and again.
// - With function 00 a port read returns the extended-address register.
// - The address register must be set first; the target is taken only from it.
// - With function 01 port accesses hit the addressed register and leave the address alone.
// - With function 10 the address steps by one after every port read or write.
// - With function 11 the address steps after port writes only.
// - Direct frames take the register number from a five-bit field over 32 16-bit registers.
module mia_indirect_access
  import mia_pkg::*;
(
  input  wire logic        clock_in,       // 125 MHz clock
  input  wire logic        rstn_in,        // async reset, active low
  input  wire logic [4:0]  reg_addr_in,    // direct register number
  input  wire logic        reg_wr_in,      // direct write strobe
  input  wire logic        reg_rd_in,      // direct read strobe
  input  wire logic [15:0] reg_wdata_in,   // direct write data
  output logic      [15:0] reg_rdata_out,  // read data
  output logic             reg_rvalid_out, // read data valid pulse
  output logic             busy_out,       // indirect read in flight
  output logic      [15:0] ext_addr_out,   // extended register address
  output logic      [15:0] ext_wdata_out,  // extended write data
  output logic             ext_wr_out,     // extended write pulse
  output logic             ext_rd_out,     // extended read pulse
  input  wire logic [15:0] ext_rdata_in,   // extended read data
  output logic      [1:0]  func_out,       // current access function
  output logic      [4:0]  sel_out         // current device selector
);

  import mia_pkg::*;

  typedef struct packed {
    mia_state_t  state;
    logic [1:0]  func;
    logic [4:0]  sel;
    logic [15:0] xaddr;
    logic [15:0] rdata;
    logic        rvalid;
    logic        busy;
    logic [15:0] eaddr;
    logic [15:0] ewdata;
    logic        ewr;
    logic        erd;
  } mia_regs_t;

  localparam mia_regs_t MIA_REGS_RST = '{
    state:  MIA_IDLE,
    func:   MIA_FUNC_RST,
    sel:    MIA_SEL_RST,
    xaddr:  MIA_XADDR_RST,
    rdata:  MIA_DATA_RST,
    rvalid: 1'b0,
    busy:   1'b0,
    eaddr:  MIA_XADDR_RST,
    ewdata: MIA_DATA_RST,
    ewr:    1'b0,
    erd:    1'b0
  };

  mia_regs_t   r_ff;
  mia_regs_t   nxt_r;
  logic        sel_ok;
  logic        target_ok;
  logic        step_wr;
  logic        step_done;
  logic [15:0] xaddr_step;

  assign sel_ok    = (r_ff.sel == MIA_SEL_GENERAL);
  assign target_ok = (r_ff.xaddr != {11'h000, MIA_CTRL_ADDR}) &&
                     (r_ff.xaddr != {11'h000, MIA_PORT_ADDR});

  assign step_wr   = (r_ff.state == MIA_IDLE);
  assign step_done = (r_ff.state == MIA_RD_WAIT) ||
                     (reg_wr_in && reg_addr_in == MIA_PORT_ADDR && sel_ok &&
                      r_ff.func != MIA_FN_ADDR && target_ok);

  mia_ptr_step u_step (
    .func_in  (r_ff.func),
    .addr_in  (r_ff.xaddr),
    .wr_in    (step_wr),
    .done_in  (step_done),
    .addr_out (xaddr_step)
  );

  always_comb begin
    nxt_r        = r_ff;
    nxt_r.rvalid = 1'b0;
    nxt_r.ewr    = 1'b0;
    nxt_r.erd    = 1'b0;
    case (r_ff.state)
      MIA_IDLE: begin
        if (reg_wr_in) begin
          if (reg_addr_in == MIA_CTRL_ADDR) begin
            nxt_r.func = reg_wdata_in[MIA_FUNC_HI:MIA_FUNC_LO];
            nxt_r.sel  = reg_wdata_in[MIA_SEL_HI:MIA_SEL_LO];
          end else if (reg_addr_in == MIA_PORT_ADDR && sel_ok) begin
            if (r_ff.func == MIA_FN_ADDR) begin
              nxt_r.xaddr = reg_wdata_in;
            end else if (target_ok) begin
              nxt_r.ewr    = 1'b1;
              nxt_r.eaddr  = r_ff.xaddr;
              nxt_r.ewdata = reg_wdata_in;
              nxt_r.xaddr  = xaddr_step;
            end
          end
        end else if (reg_rd_in) begin
          if (reg_addr_in == MIA_CTRL_ADDR) begin
            nxt_r.rdata  = {r_ff.func, 9'h000, r_ff.sel};
            nxt_r.rvalid = 1'b1;
          end else if (reg_addr_in == MIA_PORT_ADDR) begin
            if (!sel_ok) begin
              nxt_r.rdata  = MIA_IGNORED_RD;
              nxt_r.rvalid = 1'b1;
            end else if (r_ff.func == MIA_FN_ADDR) begin
              nxt_r.rdata  = r_ff.xaddr;
              nxt_r.rvalid = 1'b1;
            end else if (!target_ok) begin
              nxt_r.rdata  = MIA_IGNORED_RD;
              nxt_r.rvalid = 1'b1;
            end else begin
              nxt_r.erd   = 1'b1;
              nxt_r.eaddr = r_ff.xaddr;
              nxt_r.busy  = 1'b1;
              nxt_r.state = MIA_RD_WAIT;
            end
          end
        end
      end
      MIA_RD_WAIT: begin
        nxt_r.rdata  = ext_rdata_in;
        nxt_r.rvalid = 1'b1;
        nxt_r.busy   = 1'b0;
        nxt_r.xaddr  = xaddr_step;
        nxt_r.state  = MIA_IDLE;
      end
      default: begin
        nxt_r = MIA_REGS_RST;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_ff <= MIA_REGS_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign reg_rdata_out  = r_ff.rdata;
  assign reg_rvalid_out = r_ff.rvalid;
  assign busy_out       = r_ff.busy;
  assign ext_addr_out   = r_ff.eaddr;
  assign ext_wdata_out  = r_ff.ewdata;
  assign ext_wr_out     = r_ff.ewr;
  assign ext_rd_out     = r_ff.erd;
  assign func_out       = r_ff.func;
  assign sel_out        = r_ff.sel;

endmodule // mia_indirect_access

`default_nettype wire

// ==== testbench/mia_ext_model.sv ====
// mia_ext_model: extended register space behind the indirect access block
// assumes read data is wanted in the cycle of the read pulse
`timescale 1ns/1ps
`default_nettype none
module mia_ext_model (
  input  wire logic        clock_in,  // block clock
  input  wire logic [15:0] addr_in,   // extended address
  input  wire logic [15:0] wdata_in,  // write data
  input  wire logic        wr_in,     // write pulse
  input  wire logic        rd_in,     // read pulse
  output logic      [15:0] rdata_out  // read data
);
  logic [15:0] mem_ff [16] = '{default: 16'h0000};
  always @(posedge clock_in) if (wr_in) mem_ff[addr_in[3:0]] <= wdata_in;
  // outside a read pulse the bus shows the inverse
  assign rdata_out = rd_in ? mem_ff[addr_in[3:0]] : ~mem_ff[addr_in[3:0]];
endmodule // mia_ext_model
`default_nettype wire

// ==== testbench/mia_indirect_access_asserts.sv ====
// mia_indirect_access_asserts: port checks for mia_indirect_access
// assumes it is bound into the design top
`timescale 1ns/1ps
`default_nettype none
module mia_indirect_access_asserts
  import mia_pkg::*;
(
  input wire logic        clock_in,       // block clock
  input wire logic        rstn_in,        // async reset, active low
  input wire logic        reg_wr_in,      // direct write strobe
  input wire logic        reg_rd_in,      // direct read strobe
  input wire logic        busy_out,       // indirect read in flight
  input wire logic        reg_rvalid_out, // read data valid pulse
  input wire logic        ext_wr_out,     // extended write pulse
  input wire logic        ext_rd_out,     // extended read pulse
  input wire logic [4:0]  reg_addr_in,    // direct register number
  input wire logic [4:0]  sel_out,        // current device selector
  input wire logic [1:0]  func_out,       // current access function
  input wire logic [15:0] reg_wdata_in,   // direct write data
  input wire logic [15:0] reg_rdata_out,  // read data
  input wire logic [15:0] ext_rdata_in,   // extended read data
  input wire logic [15:0] ext_addr_out,   // extended address
  input wire logic [15:0] ext_wdata_out   // extended write data
);
  logic wgo, rgo, prt;
  assign wgo = reg_wr_in && !busy_out;
  assign rgo = reg_rd_in && !reg_wr_in && !busy_out;
  assign prt = reg_addr_in == MIA_PORT_ADDR;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  a_ctrl_write: assert property (wgo && reg_addr_in == MIA_CTRL_ADDR |=>
    {func_out, 9'h000, sel_out} == ($past(reg_wdata_in) & 16'hC01F)) else $error("ctrl write");
  a_ctrl_read: assert property (rgo && reg_addr_in == MIA_CTRL_ADDR |=>
    reg_rvalid_out && reg_rdata_out == {$past(func_out), 9'h000, $past(sel_out)})
    else $error("ctrl read");
  a_sel_read: assert property (rgo && prt && sel_out != MIA_SEL_GENERAL |=>
    reg_rvalid_out && reg_rdata_out == MIA_IGNORED_RD && !ext_rd_out) else $error("sel read");
  a_addr_func: assert property ((wgo || rgo) && prt && func_out == MIA_FN_ADDR |=>
    !ext_wr_out && !ext_rd_out) else $error("addr func forwarded");
  a_no_answer: assert property (rgo && !prt && reg_addr_in != MIA_CTRL_ADDR |=>
    !reg_rvalid_out) else $error("unmapped answered");
  a_read_data: assert property (ext_rd_out |-> busy_out ##1
    reg_rvalid_out && !busy_out && reg_rdata_out == $past(ext_rdata_in)) else $error("read data");
  a_ext_write: assert property (ext_wr_out |-> $past(wgo) && $past(prt) &&
    ext_wdata_out == $past(reg_wdata_in)) else $error("ext write cause");
  a_addr_step: assert property (ext_wr_out && func_out[1] ##1 ext_wr_out |->
    ext_addr_out == $past(ext_addr_out) + 16'h0001) else $error("no step");
endmodule // mia_indirect_access_asserts
bind mia_indirect_access mia_indirect_access_asserts u_chk (.*);
`default_nettype wire

// ==== testbench/mia_indirect_access_test.sv ====
// mia_indirect_access_test: self-checking bench for mia_indirect_access
// assumes mia_ext_model stands for the extended space
`timescale 1ns/1ps
`default_nettype none
module mia_indirect_access_test;
  import mia_pkg::*;
  localparam logic [4:0] C = MIA_CTRL_ADDR, P = MIA_PORT_ADDR;
  logic clock_in = 0, rstn_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic [4:0] reg_addr_in = '0;
  logic [15:0] reg_wdata_in = '0, d0, d1, exq[$];
  wire logic [15:0] reg_rdata_out, ext_addr_out, ext_wdata_out, ext_rdata_in;
  wire logic reg_rvalid_out, busy_out, ext_wr_out, ext_rd_out;
  wire logic [1:0] func_out;
  wire logic [4:0] sel_out;
  int n_fail = 0, tests_run = 0;
  integer seed = 24435;
  mia_indirect_access u_mia_indirect_access (.*);
  mia_ext_model u_mia_ext_model (.clock_in, .addr_in(ext_addr_out), .wdata_in(ext_wdata_out),
    .wr_in(ext_wr_out), .rd_in(ext_rd_out), .rdata_out(ext_rdata_in));
  always #4 clock_in = ~clock_in;
  task chk(input string s, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task stop_test;
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one access from just after an edge; reads leave the busy gap
  task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    reg_wr_in = w;
    reg_rd_in = !w;
    reg_addr_in = a;
    reg_wdata_in = d;
    if (!w && a inside {C, P}) exq.push_back(d);
    @(posedge clock_in) #1;
    if (!w) begin
      reg_rd_in = 0;
      repeat (2) @(posedge clock_in);
      #1;
    end
  endtask
  always @(posedge clock_in) if (reg_rvalid_out === 1'b1) begin
    if (exq.size() == 0) chk("rvalid", 16'h0000, 16'h0001);
    else chk("rdata", exq.pop_front(), reg_rdata_out);
  end
  initial begin
    #20000;
    n_fail++;
    stop_test();
  end
  initial begin
    d0 = 16'($random(seed));
    d1 = 16'($random(seed));
    // keep the two data words apart so a wrong target shows
    if (d1 == d0) d1 = ~d0;
    repeat (6) @(posedge clock_in);
    #1 rstn_in = 1;
    acc(0, C, 16'h0000);
    acc(1, C, 16'hFFFF);
    acc(0, C, 16'hC01F);
    acc(1, C, 16'h001F);
    acc(1, P, 16'h0005);
    acc(1, P, 16'h0003);
    acc(0, P, 16'h0003);
    acc(1, C, 16'h401F);
    acc(1, P, d0);
    acc(0, P, d0);
    acc(1, C, 16'h001F);
    acc(0, P, 16'h0003);
    acc(1, P, 16'hFFFF);
    acc(1, C, 16'h801F);
    acc(1, P, d1);
    acc(1, P, d0);
    acc(1, C, 16'hC01F);
    acc(0, P, 16'h0000);
    acc(1, P, d1);
    acc(1, C, 16'h001F);
    acc(0, P, 16'h0002);
    acc(1, P, 16'hFFFF);
    acc(1, C, 16'h801F);
    acc(0, P, d1);
    acc(0, P, d0);
    acc(1, C, 16'h401E);
    acc(1, P, d0);
    acc(0, P, 16'h0000);
    acc(1, C, 16'h401F);
    acc(0, P, d1);
    acc(1, C, 16'h001F);
    acc(1, P, 16'h000D);
    acc(1, C, 16'h801F);
    acc(0, P, 16'h0000);
    acc(1, P, d1);
    acc(1, C, 16'h001F);
    acc(0, P, 16'h000D);
    acc(0, 5'h03, 16'h0000);
    // mid-run reset clears control and address register
    rstn_in = 0;
    @(posedge clock_in) #1;
    rstn_in = 1;
    acc(0, C, 16'h0000);
    acc(1, C, 16'h001F);
    acc(0, P, 16'h0000);
    repeat (4) @(posedge clock_in);
    chk("pending", 16'h0000, 16'(exq.size()));
    stop_test();
  end
endmodule // mia_indirect_access_test
`default_nettype wire
